// *** rtl/tdevd_top.sv ***
// tdevd_top: event flags, dispatch delay, loss watchdog and external capture
// assumes events are one-cycle pulses on mclk; ext_in pins are asynchronous
//
// Contract
// [R01] set non-consecutive flag when received code does not follow previous one
// [R02] set external-load flag when counter loaded by external enable
// [R03] capture channels 0..3 set event flags at bits 6 to 9
// [R04] set interrupt-sent flag when distributed interrupt transmitted
// [R05] set interrupt-arrived flag when distributed interrupt received
// [R06] initiator sets code-sent flag for each transmitted time-code
// [R07] initiator sets message-due flag when message should be sent
// [R08] target sets code-received flag for each arriving time-code
// [R09] target sets locked flag when initialised or synchronised
// [R10] initiator waits 15-bit dispatch delay cycles before distributed interrupt
// [R11] target drops lock when no code within 24-bit fine-time window
// [R12] loss timeout only active while enable bit 31 set, resets zero
// [R13] software keeps timeout clear of the fine-time mapping bits
// [R14] set mask bits select inputs; match latches elapsed time
// [R15] any match clears the whole channel mask
// [R16] latched time read as low word bits 0-31, high word 32-63
// [R17] each channel reads a fixed 16-bit preamble 0x2f00
// [R18] channels 1 to 3 behave like channel 0
// [R19] software writes zero to reserved fields, ignores them on read
// [R20] shared registers behave the same in both roles
// [R21] each event flag has an enable bit at the same position
// [R22] flags stay until write-one clear; irq while flag and enable set
`timescale 1ns/100ps
`default_nettype none
module tdevd_top
  import tdevd_pkg::*;
#(
  parameter int unsigned NIN = 32
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst,
  // register port
  input  wire logic [11:0]     reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic     [31:0]      reg_rdata,
  // role and timing from the rest of the unit
  input  wire logic            is_initiator,
  input  wire logic [63:0]     et_now,
  input  wire logic            fine_tick,
  input  wire tdevd_evt_s      evt,
  input  wire logic [NIN-1:0]  ext_in,
  // outputs
  output logic                 irq_dispatch,
  output logic                 locked_indicator,
  output logic                 irq_req
);
  initial begin
    if (NIN < 1 || NIN > 32) $error("tdevd_top: NIN out of range");
  end

  tdevd_req_s req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction : hit

  // synchronise pins: first stage feeds only the second
  logic [NIN-1:0] ext_s1_r;
  logic [NIN-1:0] ext_s2_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_s1_r <= '0;
      ext_s2_r <= '0;
    end else begin
      ext_s1_r <= ext_in;
      ext_s2_r <= ext_s1_r;
    end
  end

  // registers
  logic [31:0] event_flag_register_r;
  logic [31:0] irq_en_r;
  logic [14:0] dispatch_delay_r;
  logic [23:0] loss_window_r;
  logic        loss_en_r;
  logic [7:0]  last_code_r;
  logic        have_code_r;
  logic [14:0] dly_cnt_r;
  logic        dly_run_r;
  logic [23:0] loss_cnt_r;
  logic        locked_r;

  wire wr_event = req.wr && hit(req.addr, OFS_EVENT);
  wire wr_irqen = req.wr && hit(req.addr, OFS_IRQ_EN);
  wire wr_delay = req.wr && hit(req.addr, OFS_DELAY);
  wire wr_loss  = req.wr && hit(req.addr, OFS_LOSS);

  // capture channels
  logic [NIN-1:0] cap_mask [NCHAN];
  logic [63:0]    cap_time [NCHAN];
  logic [NCHAN-1:0] cap_hit;

  genvar g;
  generate
    for (g = 0; g < NCHAN; g++) begin : g_cap // R18
      wire [11:0] base = 12'(OFS_MASK0 + 12'(g) * CHAN_STRIDE);
      tdevd_capture #(.NIN(NIN)) u_cap (
        .mclk       (mclk),
        .rst        (rst),
        .mask_wr    (req.wr && hit(req.addr, base)),
        .mask_wdata (req.wdata[NIN-1:0]),
        .ext_in     (ext_s2_r),
        .et_now     (et_now),
        .mask_r     (cap_mask[g]),
        .stamp_r    (cap_time[g]),
        .hit_r      (cap_hit[g])
      );
    end
  endgenerate

  // event sources; role-limited flags gated by role, others shared
  wire tgt = !is_initiator;
  wire noncons = evt.code_rx && have_code_r
                 && (evt.code_val != 8'(last_code_r + 8'h01)); // R01
  logic [31:0] set_vec;
  always_comb begin
    set_vec = 32'h0;
    set_vec[BIT_NONCONS] = noncons; // R01
    set_vec[BIT_EXTLOAD] = evt.ext_load; // R02
    set_vec[BIT_CAP0 +: NCHAN] = cap_hit; // R03
    set_vec[BIT_IRQ_OUT] = irq_dispatch; // R04
    set_vec[BIT_IRQ_IN]  = evt.irq_rx; // R05 R20
    set_vec[BIT_TX]  = is_initiator && evt.code_tx; // R06
    set_vec[BIT_MSG] = is_initiator && evt.msg_due; // R07
    set_vec[BIT_RX]  = tgt && evt.code_rx; // R08
    set_vec[BIT_LOCK] = tgt && evt.lock_evt; // R09
  end

  // set wins over write-one clear
  wire [31:0] clr_vec = wr_event ? req.wdata : 32'h0;
  wire [31:0] event_nxt = ((event_flag_register_r & ~clr_vec) | set_vec) & EVENT_USED; // R22

  // dispatch delay: runs after each code sent in the initiator role, fires once at zero
  wire dly_start = is_initiator && evt.code_tx; // R10
  wire dly_fire  = dly_run_r && (dly_cnt_r == 15'h0);

  // loss watchdog counts fine-time ticks since last code
  wire loss_hit = loss_en_r && tgt && locked_r && fine_tick
                  && (loss_cnt_r >= loss_window_r); // R11 R12

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      event_flag_register_r <= 32'h0;
      irq_en_r              <= 32'h0;
      dispatch_delay_r      <= DELAY_RESET;
      loss_window_r         <= LOSS_RESET;
      loss_en_r             <= 1'b0;
      last_code_r           <= 8'h00;
      have_code_r           <= 1'b0;
    end else begin
      event_flag_register_r <= event_nxt; // R22
      if (wr_irqen) irq_en_r <= req.wdata & EVENT_USED; // R21
      if (wr_delay) dispatch_delay_r <= req.wdata[14:0]; // R10
      if (wr_loss) begin
        loss_window_r <= req.wdata[23:0]; // R11
        loss_en_r     <= req.wdata[LOSS_EN_BIT]; // R12
      end
      if (evt.code_rx) begin
        last_code_r <= evt.code_val;
        have_code_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dly_cnt_r    <= 15'h0;
      dly_run_r    <= 1'b0;
      irq_dispatch <= 1'b0;
    end else begin
      irq_dispatch <= dly_fire; // R10
      if (dly_start) begin
        dly_cnt_r <= dispatch_delay_r;
        dly_run_r <= 1'b1;
      end else if (dly_run_r) begin
        dly_cnt_r <= dly_cnt_r - 15'h1;
        dly_run_r <= !dly_fire;
      end
    end
  end

  // lock tracking: code arrival restarts the window
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      loss_cnt_r <= 24'h0;
      locked_r   <= 1'b0;
    end else begin
      if (evt.code_rx) loss_cnt_r <= 24'h0;
      else if (fine_tick && loss_cnt_r != 24'hff_ffff) loss_cnt_r <= loss_cnt_r + 24'h1;
      if (tgt && evt.lock_evt) locked_r <= 1'b1;
      else if (loss_hit) locked_r <= 1'b0; // R11
    end
  end
  assign locked_indicator = locked_r;

  // read mux; reserved bits read zero
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0;
    if (hit(req.addr, OFS_EVENT)) rd_nxt = event_flag_register_r;
    if (hit(req.addr, OFS_IRQ_EN)) rd_nxt = irq_en_r;
    if (hit(req.addr, OFS_DELAY)) rd_nxt = {17'h0, dispatch_delay_r};
    if (hit(req.addr, OFS_LOSS)) rd_nxt = {loss_en_r, 7'h0, loss_window_r};
    if (hit(req.addr, OFS_STATUS)) rd_nxt = {31'h0, locked_r};
    for (int c = 0; c < NCHAN; c++) begin
      if (hit(req.addr, 12'(OFS_MASK0 + 12'(c) * CHAN_STRIDE)))
        rd_nxt = 32'(cap_mask[c]);
      if (hit(req.addr, 12'(OFS_PRE0 + 12'(c) * CHAN_STRIDE)))
        rd_nxt = {16'h0, PREAMBLE}; // R17
      if (hit(req.addr, 12'(OFS_TLO0 + 12'(c) * CHAN_STRIDE)))
        rd_nxt = cap_time[c][31:0]; // R16
      if (hit(req.addr, 12'(OFS_THI0 + 12'(c) * CHAN_STRIDE)))
        rd_nxt = cap_time[c][63:32]; // R16
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
      irq_req   <= 1'b0;
    end else begin
      reg_rdata <= req.rd ? rd_nxt : 32'h0;
      irq_req   <= |(event_nxt & irq_en_r); // R22
    end
  end

  // assertions
  sequence code_sent_s;
    is_initiator && evt.code_tx;
  endsequence

  flag_sticky_a: assert property (@(posedge mclk) disable iff (rst) // R22
    (event_flag_register_r[BIT_LOCK] && !wr_event) |=> event_flag_register_r[BIT_LOCK])
    else $error("event flag dropped without clear");
  set_wins_a: assert property (@(posedge mclk) disable iff (rst) // R05
    evt.irq_rx |=> event_flag_register_r[BIT_IRQ_IN])
    else $error("arrived flag not set");
  noncons_a: assert property (@(posedge mclk) disable iff (rst) // R01
    noncons |=> event_flag_register_r[BIT_NONCONS])
    else $error("non-consecutive code not flagged");
  role_tx_a: assert property (@(posedge mclk) disable iff (rst) // R06
    (evt.code_tx && !is_initiator && !event_flag_register_r[BIT_TX])
      |=> !event_flag_register_r[BIT_TX])
    else $error("code-sent flag set in target role");
  delay_zero_a: assert property (@(posedge mclk) disable iff (rst) // R10
    (code_sent_s and (dispatch_delay_r == 15'h0)) ##1 !dly_start |=> irq_dispatch)
    else $error("zero delay did not dispatch at once");
  delay_two_a: assert property (@(posedge mclk) disable iff (rst) // R10
    (code_sent_s and (dispatch_delay_r == 15'h2)) ##1 !dly_start [*3] |-> ##1 irq_dispatch)
    else $error("dispatch delay count wrong");
  loss_off_a: assert property (@(posedge mclk) disable iff (rst) // R12
    (!loss_en_r && !(tgt && evt.lock_evt) && locked_r) |=> locked_r)
    else $error("lock dropped with watchdog disabled");
  loss_drop_a: assert property (@(posedge mclk) disable iff (rst) // R11
    (loss_hit && !evt.lock_evt) |=> !locked_indicator)
    else $error("lock not dropped on timeout");
  irq_out_a: assert property (@(posedge mclk) disable iff (rst) // R22
    irq_req |-> |($past(event_nxt) & $past(irq_en_r)))
    else $error("interrupt request without enabled flag");
  cap_flag_a: assert property (@(posedge mclk) disable iff (rst) // R03
    cap_hit[0] |=> event_flag_register_r[BIT_CAP0])
    else $error("capture flag not set");
endmodule : tdevd_top
`default_nettype wire

// *** rtl/tdevd_pkg.sv ***
// tdevd_pkg: constants and carrier types for the time distribution event block
// assumes a 32-bit register port with word byte addresses
package tdevd_pkg;
  localparam int unsigned  NCHAN            = 4;
  localparam logic [11:0]  OFS_EVENT        = 12'h0c4;
  localparam logic [11:0]  OFS_IRQ_EN       = 12'h0c0;
  localparam logic [11:0]  OFS_DELAY        = 12'h0c8;
  localparam logic [11:0]  OFS_LOSS         = 12'h0cc;
  localparam logic [11:0]  OFS_MASK0        = 12'h100;
  localparam logic [11:0]  OFS_PRE0         = 12'h110;
  localparam logic [11:0]  OFS_TLO0         = 12'h114;
  localparam logic [11:0]  OFS_THI0         = 12'h118;
  localparam logic [11:0]  CHAN_STRIDE      = 12'h020;
  localparam logic [11:0]  OFS_STATUS       = 12'h0d0;
  localparam int unsigned  BIT_LOCK         = 0;
  localparam int unsigned  BIT_RX           = 1;
  localparam int unsigned  BIT_MSG          = 2;
  localparam int unsigned  BIT_TX           = 3;
  localparam int unsigned  BIT_IRQ_IN       = 4;
  localparam int unsigned  BIT_IRQ_OUT      = 5;
  localparam int unsigned  BIT_CAP0         = 6;
  localparam int unsigned  BIT_EXTLOAD      = 10;
  localparam int unsigned  BIT_NONCONS      = 19;
  localparam logic [31:0]  EVENT_USED       = 32'h0008_07ff;
  localparam logic [14:0]  DELAY_RESET      = 15'h7fff;
  localparam logic [23:0]  LOSS_RESET       = 24'h0f_ffff;
  localparam int unsigned  LOSS_EN_BIT      = 31;
  localparam logic [15:0]  PREAMBLE         = 16'h2f00;

  typedef struct packed {
    logic        code_rx;
    logic [7:0]  code_val;
    logic        code_tx;
    logic        msg_due;
    logic        irq_rx;
    logic        irq_tx_done;
    logic        ext_load;
    logic        lock_evt;
  } tdevd_evt_s;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tdevd_req_s;
endpackage : tdevd_pkg

// *** rtl/tdevd_capture.sv ***
// tdevd_capture: one external capture channel (mask, latch, hit pulse)
// assumes ext_in already synchronised to mclk
`timescale 1ns/100ps
`default_nettype none
module tdevd_capture
  import tdevd_pkg::*;
#(
  parameter int unsigned NIN = 32
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst,
  // control
  input  wire logic            mask_wr,
  input  wire logic [NIN-1:0]  mask_wdata,
  input  wire logic [NIN-1:0]  ext_in,
  input  wire logic [63:0]     et_now,
  // results
  output logic     [NIN-1:0]   mask_r,
  output logic     [63:0]      stamp_r,
  output logic                 hit_r
);
  initial begin
    if (NIN < 1 || NIN > 32) $error("tdevd_capture: NIN out of range");
  end

  wire              match = |(mask_r & ext_in); // R14
  wire [NIN-1:0]    mask_nxt = match ? '0 : (mask_wr ? mask_wdata : mask_r); // R15

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_r  <= '0;
      stamp_r <= 64'h0;
      hit_r   <= 1'b0;
    end else begin
      mask_r  <= mask_nxt;
      hit_r   <= match;
      if (match) stamp_r <= et_now; // R14
    end
  end

  mask_clear_a: assert property (@(posedge mclk) disable iff (rst)
    match |=> (mask_r == '0) && hit_r && (stamp_r == $past(et_now))) // R15
    else $error("capture did not clear mask or latch time");
endmodule : tdevd_capture
`default_nettype wire

// *** testbench/tdevd_peer.sv ***
// tdevd_peer: remote node model sending time-codes and fine-time ticks
// assumes send and jump are one-cycle requests from the bench on mclk
`timescale 1ns/100ps
`default_nettype none
module tdevd_peer
  import tdevd_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // requests
  input  wire logic       send,
  input  wire logic       jump,
  // link side
  output logic            code_rx,
  output logic [7:0]      code_val,
  output logic            fine_tick
);
  logic [1:0] tick_r;
  logic [7:0] val_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_r  <= 2'h0;
      code_rx <= 1'b0;
      val_r   <= 8'h00;
    end else begin
      tick_r  <= tick_r + 2'h1;
      code_rx <= send;
      // a skipped step is how the far side shows a lost code
      if (send) val_r <= val_r + (jump ? 8'h02 : 8'h01);
    end
  end
  // value is only meaningful beside code_rx, so show junk outside it
  assign code_val  = code_rx ? val_r : ~val_r;
  assign fine_tick = (tick_r == 2'h3);
endmodule : tdevd_peer
`default_nettype wire

// *** testbench/tb_time_distribution_events_datation.sv ***
// tb_time_distribution_events_datation: random and corner tests of tdevd_top
// assumes the peer model supplies time-codes and fine ticks
`timescale 1ns/100ps
`default_nettype none
module tb_time_distribution_events_datation;
  import tdevd_pkg::*;
  logic        mclk, rst, reg_wr, reg_rd, is_initiator;
  logic        irq_dispatch, locked_indicator, irq_req;
  logic        send, jump, p_rx, p_tick;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd, v, ext_in;
  logic [63:0] et_now, et_cap;
  logic [5:0]  pul;
  logic [7:0]  p_val;
  tdevd_evt_s  evt;
  int          num_errors, check_count, n, sel;
  // the last two entries are role-limited events in the wrong role: no flag expected
  int          ev_pul[7] = '{4, 3, 3, 1, 0, 5, 4};
  logic [31:0] ev_exp[7] = '{32'h1 << BIT_MSG, 32'h1 << BIT_IRQ_IN, 32'h1 << BIT_IRQ_IN,
                             32'h1 << BIT_EXTLOAD, 32'h1 << BIT_LOCK, 32'h0, 32'h0};
  logic        ev_role[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  assign evt = {p_rx, p_val, pul};

  tdevd_top tdevd_top_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .is_initiator(is_initiator),
    .et_now(et_now), .fine_tick(p_tick), .evt(evt), .ext_in(ext_in),
    .irq_dispatch(irq_dispatch), .locked_indicator(locked_indicator), .irq_req(irq_req));
  tdevd_peer tdevd_peer_i (.mclk(mclk), .rst(rst), .send(send), .jump(jump), .code_rx(p_rx),
    .code_val(p_val), .fine_tick(p_tick));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] flag(input int b);
    return 32'h1 << b;
  endfunction : flag
  function automatic logic [11:0] ca(input int c, input logic [11:0] base);
    return base + CHAN_STRIDE * 12'(c);
  endfunction : ca

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdt(input logic [11:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdt
  task automatic pulse(input int b);
    @(posedge mclk);
    pul[b] <= 1'b1;
    @(posedge mclk);
    pul[b] <= 1'b0;
  endtask : pulse
  task automatic code(input logic j);
    @(posedge mclk);
    send <= 1'b1;
    jump <= j;
    @(posedge mclk);
    send <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : code

  initial begin
    {reg_wr, reg_rd, send, jump, is_initiator} = 5'h00;
    {reg_addr, reg_wdata, ext_in, pul, et_now} = '0;
    num_errors = 0;
    check_count = 0;
    rst = 1'b1;
    n = $urandom(47605);
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rdt(OFS_EVENT); check(rd, 32'h0, "flags");
    rdt(OFS_DELAY); check(rd, {17'h0, DELAY_RESET}, "delay");
    rdt(OFS_LOSS); check(rd, {8'h0, LOSS_RESET}, "loss");
    for (int c = 0; c < 4; c++) begin
      wr(ca(c, OFS_PRE0), 32'h0000_1234);
      rdt(ca(c, OFS_PRE0)); check(rd, {16'h0, PREAMBLE}, "preamble");
    end
    rdt(12'h0fc); check(rd, 32'h0, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      wr(OFS_IRQ_EN, (i % 2) ? EVENT_USED : 32'h0);
      is_initiator <= ev_role[i];
      rdt(OFS_IRQ_EN); check(rd, (i % 2) ? EVENT_USED : 32'h0, "irq enable");
      pulse(ev_pul[i]);
      repeat (2) @(posedge mclk);
      #1 check({31'h0, irq_req}, {31'h0, (i % 2 == 1) && (ev_exp[i] != 32'h0)}, "irq");
      rdt(OFS_EVENT); check(rd, ev_exp[i], "event");
      wr(OFS_EVENT, ev_exp[i]);
      rdt(OFS_EVENT); check(rd, 32'h0, "clear");
    end
    $display("test events done");
    // zero and two are corner delays; the others are random
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 32'h0 : (k == 2) ? 32'h2 : $urandom_range(40, 3);
      wr(OFS_DELAY, v);
      rdt(OFS_DELAY); check(rd, v, "delay rw");
      is_initiator <= 1'b1;
      // a second code mid-count must restart the wait
      if (k == 1) begin
        pulse(5);
        repeat (2) @(posedge mclk);
      end
      pulse(5);
      n = 0;
      while (irq_dispatch !== 1'b1 && n < 200) begin
        @(posedge mclk);
        n++;
        #1;
      end
      // pulse seen one edge after the count reaches zero
      check(32'(n), v + 32'h1, "dispatch wait");
      @(posedge mclk);
      #1 check({31'h0, irq_dispatch}, 32'h0, "dispatch pulse");
      rdt(OFS_EVENT); check(rd, flag(BIT_TX) | flag(BIT_IRQ_OUT), "sent");
      wr(OFS_EVENT, EVENT_USED);
    end
    $display("test dispatch done");
    is_initiator <= 1'b0;
    code(1'b0);
    code(1'b0);
    rdt(OFS_EVENT); check(rd, flag(BIT_RX), "received");
    wr(OFS_EVENT, flag(BIT_RX));
    code(1'b1);
    rdt(OFS_EVENT); check(rd, flag(BIT_RX) | flag(BIT_NONCONS), "gap");
    wr(OFS_EVENT, EVENT_USED);
    $display("test codes done");
    pulse(0);
    wr(OFS_LOSS, 32'h0000_0003);
    repeat (60) @(posedge mclk);
    #1 check({31'h0, locked_indicator}, 32'h1, "lock held");
    wr(OFS_LOSS, 32'h8000_0003);
    rdt(OFS_LOSS); check(rd, 32'h8000_0003, "loss rw");
    n = 0;
    while (locked_indicator !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
      #1;
    end
    check({31'h0, n < 100}, 32'h1, "lock lost");
    rdt(OFS_STATUS); check(rd & 32'h1, 32'h0, "status");
    wr(OFS_LOSS, 32'h0);
    wr(OFS_EVENT, EVENT_USED);
    $display("test loss done");
    for (int c = 0; c < 4; c++) begin
      sel = $urandom_range(31, 0);
      // extra mask bits check that one hit clears them all
      v = $urandom | flag(sel);
      wr(ca(c, OFS_MASK0), v);
      rdt(ca(c, OFS_MASK0)); check(rd, v, "mask");
      et_cap = {$urandom, $urandom};
      et_now <= et_cap;
      ext_in[sel] <= 1'b1;
      repeat (6) @(posedge mclk);
      ext_in <= 32'h0;
      et_now <= {$urandom, $urandom};
      rdt(ca(c, OFS_MASK0)); check(rd, 32'h0, "mask clr");
      rdt(ca(c, OFS_TLO0)); check(rd, et_cap[31:0], "time lo");
      rdt(ca(c, OFS_THI0)); check(rd, et_cap[63:32], "time hi");
      rdt(OFS_EVENT); check(rd, flag(BIT_CAP0 + c), "hit");
      wr(OFS_EVENT, EVENT_USED);
    end
    $display("test capture done");
    report_and_stop();
  end
endmodule : tb_time_distribution_events_datation
`default_nettype wire
